// ### rtl/rwcm_pkg.sv
// rwcm_pkg: constants for the reset, watchdog and clock monitor block.
// assumes a 10 MHz clock; shared by the design and its bench.
package rwcm_pkg;

    // clock rate and timing
    localparam int CLK_HZ           = 10_000_000;
    localparam int POR_OSC_CYCLES   = 4064;
    localparam int PIN_DRIVE_CYCLES = 4;
    localparam int CKMON_TIMEOUT_US = 50;
    localparam int CKMON_CYCLES     = CKMON_TIMEOUT_US * (CLK_HZ / 1_000_000);
    localparam int WDOG_BASE_DIV    = 32768;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_SERVICE = 6'h1d;
    localparam logic [5:0] IDX_CONTROL = 6'h1e;

    // control register fields
    localparam int CTL_SEL_LO = 0;
    localparam int CTL_SEL_HI = 1;
    localparam int CTL_WDOG   = 2;
    localparam int CTL_CKCHK  = 3;
    localparam int CTL_FLAG   = 4;

    // service sequence values
    localparam logic [7:0] SVC_ARM  = 8'h55;
    localparam logic [7:0] SVC_DONE = 8'hAA;

    // restart vector and core reset values
    localparam logic [15:0] VEC_HI_ADR   = 16'h1ffe;
    localparam logic [15:0] VEC_LO_ADR   = 16'h1fff;
    localparam logic [15:0] SP_RESET     = 16'h00ff;
    localparam logic [15:0] TIMER_RESET  = 16'hfffc;
    localparam logic [7:0]  DDR_RESET    = 8'h00;
    localparam logic        IMASK_RESET  = 1'b1;
    localparam logic        TXEMPTY_RST  = 1'b1;
    localparam logic        TXDONE_RST   = 1'b1;

    // reset sequencer states
    typedef enum logic [5:0] {
        ST_POR  = 6'b00_0001,
        ST_DRV  = 6'b00_0010,
        ST_HOLD = 6'b00_0100,
        ST_VHI  = 6'b00_1000,
        ST_VLO  = 6'b01_0000,
        ST_RUN  = 6'b10_0000
    } rwcm_state_e;

endpackage

// ### rtl/rwcm_top.sv
// rwcm_top: reset control with watchdog and clock monitor.
// assumes clk_i is a free 10 MHz reference, bus_tick_i marks
// each bus clock cycle, vec_dat_i answers in the same cycle as vec_adr_o.
//
// Contract
// - reset comes from pin, power-on, watchdog timeout or clock loss
// - power-on reset fires only on a rising supply edge
// - power-on holds reset 4064 oscillator cycles after oscillator starts
// - pin still low after power-on delay keeps the core in reset
// - reset clears ddrs, sets sp 00ff, sets mask, clears latches
// - reset disables async port and sets its flags to reset values
// - reset disables sync port as peripheral, clears its bits
// - reset zeroes timer prescaler, loads ffff-3, clears timer bits
// - on exit, pc high from 1ffe and low from 1fff
// - enabled watchdog timeout causes a system reset
// - flag set by watchdog or monitor reset, cleared by pin or power
// - reading the control register clears the flag
// - monitor enable bit is read and write at any time
// - period select divides bus clock over 2^15 by 1,4,16,64
// - period select resets to 00
// - writing 55 then aa restarts the watchdog count
// - any access except a service write of a value other than 55 may fall between the two service writes
// - watchdog or monitor reset drives the pin low four cycles
// - enabled monitor resets when the bus clock stops too long
// - monitor reset uses the ordinary restart vector
// - enabled monitor resets at stop entry
`timescale 1ns/1ps
`default_nettype none
module rwcm_top #(
    parameter int WDOG_DIV = rwcm_pkg::WDOG_BASE_DIV
) (
    // clock and flop reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // power, oscillator and core status
    input  wire logic        por_i,
    input  wire logic        osc_ok_i,
    input  wire logic        bus_tick_i,
    input  wire logic        stop_i,
    // reset pin, open drain
    input  wire logic        rst_pin_i,
    output logic             rst_pin_o,
    output logic             rst_pin_oe_o,
    // reset to core and peripherals
    output logic             sys_rst_o,
    // restart vector fetch
    output logic      [15:0] vec_adr_o,
    output logic             vec_rd_o,
    input  wire logic [7:0]  vec_dat_i,
    output logic      [15:0] pc_o
);

    localparam int WCW = 22;
    localparam int CKW = 10;
    localparam logic [11:0] POR_LAST = 12'(rwcm_pkg::POR_OSC_CYCLES - 1);
    localparam logic [2:0]  DRV_LAST = 3'(rwcm_pkg::PIN_DRIVE_CYCLES - 1);
    localparam logic [CKW-1:0] CK_LAST = CKW'(rwcm_pkg::CKMON_CYCLES - 1);

    // watchdog limit for a period select code
    function automatic logic [WCW-1:0] wdog_limit(input logic [1:0] s);
        wdog_limit = WCW'(WDOG_DIV) << (2 * s);
    endfunction

    // pin and power inputs pass two flops
    logic [1:0] pin_sync_reg;
    logic [1:0] por_sync_reg;
    logic [1:0] osc_sync_reg;
    logic       por_last_reg;
    logic       pin_s;
    logic       por_s;
    logic       osc_s;
    logic       por_rise;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_sync_reg <= 2'h3;
            por_sync_reg <= 2'h0;
            osc_sync_reg <= 2'h0;
            por_last_reg <= 1'b0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[0], rst_pin_i};
            por_sync_reg <= {por_sync_reg[0], por_i};
            osc_sync_reg <= {osc_sync_reg[0], osc_ok_i};
            por_last_reg <= por_sync_reg[1];
        end
    end
    assign pin_s    = pin_sync_reg[1];
    assign por_s    = por_sync_reg[1];
    assign osc_s    = osc_sync_reg[1];
    assign por_rise = por_s & ~por_last_reg;

    // register file state
    logic [1:0] sel_reg, sel_next;
    logic       wd_on_reg, wd_on_next;
    logic       ck_on_reg, ck_on_next;
    logic       flag_reg, flag_next;
    logic       armed_reg, armed_next;
    logic       ack_reg, ack_next;
    logic [31:0] rd_reg, rd_next;
    // sequencer and counters
    rwcm_pkg::rwcm_state_e st_reg, st_next;
    logic [11:0]   por_cnt_reg, por_cnt_next;
    logic [2:0]    drv_cnt_reg, drv_cnt_next;
    logic [WCW-1:0] wd_cnt_reg, wd_cnt_next;
    logic [CKW-1:0] ck_cnt_reg, ck_cnt_next;
    logic          ck_lost_reg, ck_lost_next;
    logic [15:0]   vadr_reg, vadr_next;
    logic          vrd_reg, vrd_next;
    logic [15:0]   pc_reg, pc_next;
    logic          srst_reg, srst_next;
    logic          pin_oe_reg, pin_oe_next;

    // bus decode
    logic req, wr_acc, rd_acc, hit_svc, hit_ctl;
    logic svc_wr, ctl_wr, ctl_rd, svc_done, run;
    logic wd_fire, ck_fire, ext_rst, fail;
    assign req     = cyc_i & stb_i & ~ack_reg;
    assign wr_acc  = req & we_i & sel_i[0];
    assign rd_acc  = req & ~we_i;
    assign hit_svc = adr_i[7:2] == rwcm_pkg::IDX_SERVICE;
    assign hit_ctl = adr_i[7:2] == rwcm_pkg::IDX_CONTROL;
    assign svc_wr  = wr_acc & hit_svc;
    assign ctl_wr  = wr_acc & hit_ctl;
    assign ctl_rd  = rd_acc & hit_ctl;
    assign run     = st_reg == rwcm_pkg::ST_RUN;
    assign svc_done = svc_wr & armed_reg
                    & (dat_i[7:0] == rwcm_pkg::SVC_DONE);

    // reset causes while running
    assign wd_fire = run & wd_on_reg & bus_tick_i
                   & (wd_cnt_reg == wdog_limit(sel_reg) - 1'b1);
    assign ck_fire = run & ck_on_reg
                   & ((ck_cnt_reg == CK_LAST) | stop_i);
    assign ext_rst = run & ~pin_s;
    assign fail    = wd_fire | ck_fire;

    // register file next values
    always_comb begin
        sel_next   = sel_reg;
        wd_on_next = wd_on_reg;
        ck_on_next = ck_on_reg;
        flag_next  = flag_reg;
        armed_next = armed_reg;
        ack_next   = cyc_i & stb_i & ~ack_reg;
        rd_next    = 32'h0000_0000; // unmapped reads as zero
        if (ctl_rd) begin
            rd_next[rwcm_pkg::CTL_SEL_HI:rwcm_pkg::CTL_SEL_LO] = sel_reg;
            rd_next[rwcm_pkg::CTL_WDOG]  = wd_on_reg;
            rd_next[rwcm_pkg::CTL_CKCHK] = ck_on_reg;
            rd_next[rwcm_pkg::CTL_FLAG]  = flag_reg;
            flag_next = 1'b0;
        end
        if (ctl_wr) begin
            sel_next   = dat_i[rwcm_pkg::CTL_SEL_HI:rwcm_pkg::CTL_SEL_LO];
            wd_on_next = dat_i[rwcm_pkg::CTL_WDOG];
            ck_on_next = dat_i[rwcm_pkg::CTL_CKCHK];
        end
        // arming survives unrelated accesses
        if (svc_wr) begin
            armed_next = dat_i[7:0] == rwcm_pkg::SVC_ARM;
        end
        // pin or power reset clears the flag
        if (por_rise | ext_rst) begin
            flag_next = 1'b0;
        end
        // a failure reset sets it and wins over a read
        if (fail) begin
            flag_next = 1'b1;
        end
        // any reset returns controls to defaults
        if (por_rise | ext_rst | fail) begin
            sel_next   = 2'h0;
            wd_on_next = 1'b0;
            ck_on_next = 1'b0;
            armed_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_reg   <= 2'h0;
            wd_on_reg <= 1'b0;
            ck_on_reg <= 1'b0;
            flag_reg  <= 1'b0;
            armed_reg <= 1'b0;
            ack_reg   <= 1'b0;
            rd_reg    <= 32'h0000_0000;
        end else begin
            sel_reg   <= sel_next;
            wd_on_reg <= wd_on_next;
            ck_on_reg <= ck_on_next;
            flag_reg  <= flag_next;
            armed_reg <= armed_next;
            ack_reg   <= ack_next;
            rd_reg    <= rd_next;
        end
    end

    // watchdog and clock monitor counters
    always_comb begin
        wd_cnt_next = wd_cnt_reg;
        if (!run || !wd_on_reg || svc_done) begin
            wd_cnt_next = '0;
        end else if (bus_tick_i) begin
            wd_cnt_next = wd_cnt_reg + 1'b1;
        end
        ck_cnt_next = ck_cnt_reg + 1'b1;
        if (bus_tick_i || !run || ck_cnt_reg == CK_LAST) begin
            ck_cnt_next = '0;
        end
    end

    // reset sequencer; every cause ends in the one vector fetch
    always_comb begin
        st_next      = st_reg;
        por_cnt_next = por_cnt_reg;
        drv_cnt_next = drv_cnt_reg;
        ck_lost_next = ck_lost_reg;
        vadr_next    = vadr_reg;
        vrd_next     = 1'b0;
        pc_next      = pc_reg;
        case (st_reg)
            rwcm_pkg::ST_POR: begin
                if (osc_s) begin
                    por_cnt_next = por_cnt_reg + 1'b1;
                    if (por_cnt_reg == POR_LAST) begin
                        st_next = rwcm_pkg::ST_HOLD;
                    end
                end
            end
            rwcm_pkg::ST_DRV: begin
                // a lost bus clock gives no ticks, so count reference
                if (bus_tick_i || ck_lost_reg) begin
                    drv_cnt_next = drv_cnt_reg + 1'b1;
                    if (drv_cnt_reg == DRV_LAST) begin
                        st_next = rwcm_pkg::ST_HOLD;
                    end
                end
            end
            rwcm_pkg::ST_HOLD: begin
                if (pin_s) begin
                    st_next   = rwcm_pkg::ST_VHI;
                    vadr_next = rwcm_pkg::VEC_HI_ADR;
                    vrd_next  = 1'b1;
                end
            end
            rwcm_pkg::ST_VHI: begin
                pc_next[15:8] = vec_dat_i;
                vadr_next = rwcm_pkg::VEC_LO_ADR;
                vrd_next  = 1'b1;
                st_next   = rwcm_pkg::ST_VLO;
            end
            rwcm_pkg::ST_VLO: begin
                pc_next[7:0] = vec_dat_i;
                st_next = rwcm_pkg::ST_RUN;
            end
            rwcm_pkg::ST_RUN: begin
                if (fail) begin
                    st_next      = rwcm_pkg::ST_DRV;
                    drv_cnt_next = 3'h0;
                    ck_lost_next = ck_fire;
                end else if (ext_rst) begin
                    st_next = rwcm_pkg::ST_HOLD;
                end
            end
            default: begin
                st_next = rwcm_pkg::ST_POR;
            end
        endcase
        // a rising supply restarts from anywhere
        if (por_rise) begin
            st_next      = rwcm_pkg::ST_POR;
            por_cnt_next = 12'h000;
            vrd_next     = 1'b0;
        end
    end

    // outputs registered from the next state
    always_comb begin
        srst_next   = st_next != rwcm_pkg::ST_RUN;
        pin_oe_next = st_next == rwcm_pkg::ST_DRV;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg      <= rwcm_pkg::ST_POR;
            por_cnt_reg <= 12'h000;
            drv_cnt_reg <= 3'h0;
            wd_cnt_reg  <= '0;
            ck_cnt_reg  <= '0;
            ck_lost_reg <= 1'b0;
            vadr_reg    <= 16'h0000;
            vrd_reg     <= 1'b0;
            pc_reg      <= 16'h0000;
            srst_reg    <= 1'b1;
            pin_oe_reg  <= 1'b0;
        end else begin
            st_reg      <= st_next;
            por_cnt_reg <= por_cnt_next;
            drv_cnt_reg <= drv_cnt_next;
            wd_cnt_reg  <= wd_cnt_next;
            ck_cnt_reg  <= ck_cnt_next;
            ck_lost_reg <= ck_lost_next;
            vadr_reg    <= vadr_next;
            vrd_reg     <= vrd_next;
            pc_reg      <= pc_next;
            srst_reg    <= srst_next;
            pin_oe_reg  <= pin_oe_next;
        end
    end

    // port drivers
    assign dat_o        = rd_reg;
    assign ack_o        = ack_reg;
    assign rst_pin_o    = 1'b0; // open drain, low only
    assign rst_pin_oe_o = pin_oe_reg;
    assign sys_rst_o    = srst_reg;
    assign vec_adr_o    = vadr_reg;
    assign vec_rd_o     = vrd_reg;
    assign pc_o         = pc_reg;

    // bus ticks seen while the pin is driven, for the drive length check
    logic [3:0] drv_seen_reg, drv_seen_next;
    always_comb begin
        drv_seen_next = 4'h0;
        if (rst_pin_oe_o) begin
            drv_seen_next = drv_seen_reg + {3'h0, bus_tick_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_seen_reg <= 4'h0;
        end else begin
            drv_seen_reg <= drv_seen_next;
        end
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_por_restart: assert property (por_rise |=> st_reg == rwcm_pkg::ST_POR
        && por_cnt_reg == 12'h000) else $error("supply rise did not restart");
    a_por_hold: assert property (st_reg == rwcm_pkg::ST_POR && !por_rise
        |=> sys_rst_o) else $error("reset dropped in power-on wait");
    a_hold_pin: assert property (st_reg == rwcm_pkg::ST_HOLD && !pin_s
        |=> st_reg == rwcm_pkg::ST_HOLD || $past(por_rise))
        else $error("left hold with pin low");
    a_wdog_fire: assert property (wd_fire && !por_rise |=> st_reg == rwcm_pkg::ST_DRV
        && flag_reg && rst_pin_oe_o) else $error("timeout gave no reset");
    a_stop_reset: assert property (run && ck_on_reg && stop_i && !por_rise
        |=> st_reg == rwcm_pkg::ST_DRV) else $error("stop did not reset");
    a_ext_clear: assert property (ext_rst && !fail && !por_rise |=> !flag_reg
        && st_reg == rwcm_pkg::ST_HOLD) else $error("pin reset kept flag");
    a_read_clear: assert property (ctl_rd && !fail |=> !flag_reg ##1 ack_o == 1'b0)
        else $error("read left flag set");
    a_serv_restart: assert property (svc_done |=> wd_cnt_reg == '0)
        else $error("service did not restart");
    a_serv_disarm: assert property (svc_wr && dat_i[7:0] != rwcm_pkg::SVC_ARM
        |=> !armed_reg) else $error("bad value left armed");
    a_lone_done: assert property (!armed_reg && svc_wr && run && wd_on_reg
        && !fail && !ext_rst && !por_rise
        |=> wd_cnt_reg == $past(wd_cnt_reg) + WCW'($past(bus_tick_i)))
        else $error("lone completing write restarted");
    a_pin_drive: assert property ($fell(rst_pin_oe_o) && !ck_lost_reg && !$past(por_rise)
        |-> drv_seen_reg == 4'h4)
        else $error("pin drive length wrong");
    a_vector: assert property (st_reg == rwcm_pkg::ST_VHI && !por_rise
        |=> vec_adr_o == rwcm_pkg::VEC_LO_ADR && pc_o[15:8] == $past(vec_dat_i)
        ##1 pc_o[7:0] == $past(vec_dat_i) && !sys_rst_o)
        else $error("vector fetch wrong");

    c_wdog_reset: cover property (wd_fire);
    c_ck_reset: cover property (ck_fire && !stop_i);
    c_service: cover property (svc_done);
    c_vector: cover property (st_reg == rwcm_pkg::ST_VLO);

endmodule
`default_nettype wire

// ### verif/rwcm_ext_model.sv
// rwcm_ext_model: far side of the reset block, the open-drain reset
// line with its pull-up, and the memory holding the restart vector.
// assumes the same clock as the block; the bench pulls the line low.
`timescale 1ns/1ps
`default_nettype none
module rwcm_ext_model #(
    parameter logic [7:0] VEC_HI = 8'h3c,
    parameter logic [7:0] VEC_LO = 8'h5a
) (
    // clock
    input  wire logic        clk_i,
    // reset line parties
    input  wire logic        pin_oe_i,
    input  wire logic        ext_low_i,
    output logic             pin_o,
    // vector memory port
    input  wire logic [15:0] vec_adr_i,
    input  wire logic        vec_rd_i,
    output logic      [7:0]  vec_dat_o
);
    logic [7:0] junk_reg = 8'h96;

    // pull-up wins unless a party pulls the line low
    assign pin_o = ~(pin_oe_i | ext_low_i);

    // filler that changes every cycle, so stale data never matches
    always_ff @(posedge clk_i) begin
        junk_reg <= ~junk_reg + 8'h01;
    end

    // byte answers in the same cycle as the address, with no register
    assign vec_dat_o = !vec_rd_i ? junk_reg :
                       (vec_adr_i == rwcm_pkg::VEC_HI_ADR) ? VEC_HI : VEC_LO;
endmodule
`default_nettype wire

// ### verif/tb_rwcm_top.sv
// tb_rwcm_top: self-checking bench for the reset, watchdog and clock monitor block.
// assumes a 10 MHz clock, a bus tick every eighth clock, and a short watchdog base.
`timescale 1ns/1ps
`default_nettype none
module tb_rwcm_top;
    localparam logic [7:0]  A_SVC  = {rwcm_pkg::IDX_SERVICE, 2'b00};
    localparam logic [7:0]  A_CTL  = {rwcm_pkg::IDX_CONTROL, 2'b00};
    localparam logic [15:0] PC_EXP = 16'h3c5a;

    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h1;
    logic [31:0] dat_i = 32'h0000_0000, dat_o, rd;
    logic        ack_o, por_i = 1'b0, osc_ok_i = 1'b0, bus_tick_i = 1'b0, stop_i = 1'b0;
    logic        rst_pin_i, rst_pin_o, rst_pin_oe_o, sys_rst_o, vec_rd_o, ext_low = 1'b0;
    logic        tick_en = 1'b1;
    logic [2:0]  tdiv = 3'h0;
    logic [15:0] vec_adr_o, pc_o;
    logic [7:0]  vec_dat_i;
    int          failures = 0, comparisons = 0, n, lim;

    // free clock
    always #50 clk_i = ~clk_i;

    // one bus tick every eighth clock while enabled
    always @(posedge clk_i) begin
        tdiv       <= tdiv + 3'h1;
        bus_tick_i <= tick_en && (tdiv == 3'h7);
    end

    rwcm_top #(.WDOG_DIV(4)) u_rwcm_top (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .por_i(por_i), .osc_ok_i(osc_ok_i), .bus_tick_i(bus_tick_i), .stop_i(stop_i),
        .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o),
        .sys_rst_o(sys_rst_o), .vec_adr_o(vec_adr_o), .vec_rd_o(vec_rd_o),
        .vec_dat_i(vec_dat_i), .pc_o(pc_o)
    );

    rwcm_ext_model #(.VEC_HI(PC_EXP[15:8]), .VEC_LO(PC_EXP[7:0])) u_rwcm_ext_model (
        .clk_i(clk_i), .pin_oe_i(rst_pin_oe_o), .ext_low_i(ext_low), .pin_o(rst_pin_i),
        .vec_adr_i(vec_adr_o), .vec_rd_i(vec_rd_o), .vec_dat_o(vec_dat_i)
    );

    // counted comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // classic wishbone cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd);
        int k;
        k = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= we;
        adr_i <= adr;
        dat_i <= {24'h00_0000, wd};
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        chk(32'(ack_o), 32'h0000_0001);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    // cycles until the core reset reaches a level
    task automatic wait_rst(input logic lvl, input int lim_i);
        n = 0;
        while (sys_rst_o !== lvl && n < lim_i) begin
            @(posedge clk_i);
            n++;
        end
        chk(32'(n < lim_i), 32'h0000_0001);
    endtask

    // length of the pin drive, in bus ticks or in clocks
    task automatic pin_cnt(input logic by_tick);
        int k;
        k = 0;
        n = 0;
        while (rst_pin_oe_o !== 1'b1 && k < 20) begin
            @(posedge clk_i);
            k++;
        end
        chk(32'(rst_pin_o), 32'h0000_0000);
        while (rst_pin_oe_o === 1'b1 && k < 200) begin
            if (!by_tick || bus_tick_i === 1'b1) n++;
            @(posedge clk_i);
            k++;
        end
        chk(32'(n), 32'h0000_0004);
    endtask

    task automatic t_por;
        por_i    <= 1'b1;
        osc_ok_i <= 1'b1;
        repeat (4060) @(posedge clk_i);
        chk(32'(sys_rst_o), 32'h0000_0001);
        wait_rst(1'b0, 40);
        chk({16'h0000, pc_o}, {16'h0000, PC_EXP});
        por_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        chk(32'(sys_rst_o), 32'h0000_0000);
        $display("test power-on done");
    endtask

    task automatic t_regs;
        wb(1'b0, A_CTL, 8'h00);
        chk(rd, 32'h0000_0000);
        wb(1'b1, A_CTL, 8'h0b);
        wb(1'b0, A_CTL, 8'h00);
        chk(rd, 32'h0000_000b);
        wb(1'b1, A_CTL, 8'h00);
        wb(1'b0, A_CTL, 8'h00);
        chk(rd, 32'h0000_0000);
        wb(1'b0, 8'h7c, 8'h00);
        chk(rd, 32'h0000_0000);
        wb(1'b0, A_SVC, 8'h00);
        chk(rd, 32'h0000_0000);
        $display("test registers done");
    endtask

    task automatic t_wdog;
        for (int s = 0; s < 4; s++) begin
            wb(1'b1, A_CTL, 8'h04 | 8'(s));
            wb(1'b1, A_SVC, rwcm_pkg::SVC_ARM);
            wb(1'b1, A_SVC, rwcm_pkg::SVC_DONE);
            wait_rst(1'b1, 3000);
            lim = 32 << (2 * s);
            chk(32'(n > lim - 18 && n <= lim + 4), 32'h0000_0001);
            pin_cnt(1'b1);
            wait_rst(1'b0, 100);
            chk({16'h0000, pc_o}, {16'h0000, PC_EXP});
            wb(1'b0, A_CTL, 8'h00);
            chk(rd, 32'h0000_0010);
        end
        wb(1'b0, A_CTL, 8'h00);
        chk(rd, 32'h0000_0000);
        $display("test watchdog periods done");
    endtask

    task automatic t_svc;
        wb(1'b1, A_CTL, 8'h05);
        // services spaced inside the 128-clock period
        for (int i = 0; i < 6; i++) begin
            repeat (40) @(posedge clk_i);
            wb(1'b1, A_SVC, rwcm_pkg::SVC_ARM);
            wb(1'b0, A_CTL, 8'h00);
            wb(1'b1, A_SVC, rwcm_pkg::SVC_DONE);
        end
        chk(32'(sys_rst_o), 32'h0000_0000);
        repeat (60) @(posedge clk_i);
        wb(1'b1, A_SVC, rwcm_pkg::SVC_DONE);
        wb(1'b1, A_SVC, rwcm_pkg::SVC_ARM);
        wb(1'b1, A_SVC, 8'h12);
        wb(1'b1, A_SVC, rwcm_pkg::SVC_DONE);
        wait_rst(1'b1, 200);
        chk(32'(n < 80), 32'h0000_0001);
        pin_cnt(1'b1);
        wait_rst(1'b0, 100);
        $display("test service sequence done");
    endtask

    task automatic t_pin;
        ext_low <= 1'b1;
        wait_rst(1'b1, 10);
        repeat (300) @(posedge clk_i);
        chk(32'(sys_rst_o), 32'h0000_0001);
        ext_low <= 1'b0;
        wait_rst(1'b0, 20);
        chk({16'h0000, pc_o}, {16'h0000, PC_EXP});
        wb(1'b0, A_CTL, 8'h00);
        chk(rd, 32'h0000_0000);
        $display("test reset pin done");
    endtask

    task automatic t_ckmon;
        tick_en <= 1'b0;
        wb(1'b1, A_CTL, 8'h08);
        wait_rst(1'b1, 700);
        chk(32'(n > 470 && n < 515), 32'h0000_0001);
        pin_cnt(1'b0);
        tick_en <= 1'b1;
        wait_rst(1'b0, 50);
        chk({16'h0000, pc_o}, {16'h0000, PC_EXP});
        wb(1'b0, A_CTL, 8'h00);
        chk(rd, 32'h0000_0010);
        wb(1'b1, A_CTL, 8'h08);
        repeat (1000) @(posedge clk_i);
        chk(32'(sys_rst_o), 32'h0000_0000);
        stop_i <= 1'b1;
        @(posedge clk_i);
        stop_i <= 1'b0;
        wait_rst(1'b1, 10);
        pin_cnt(1'b0);
        wait_rst(1'b0, 50);
        $display("test clock monitor done");
    endtask

    // verdict and end of run
    task automatic close_out;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_por;
        t_regs;
        t_wdog;
        t_svc;
        t_pin;
        t_ckmon;
        close_out;
    end

    // hang guard, about three times the expected run
    initial begin
        #3_000_000;
        failures++;
        close_out;
    end
endmodule
`default_nettype wire
